// >>> shared/rdc_pkg.sv
// Summary of operation
// - Each channel's swing register at driver_swing_control uses bits 2:0 to pick one of eight output amplitudes, 0.6 V for code 0 and 0.1 V more per step, up to 1.3 V.
// - Each channel's de-emphasis register at driver_deemphasis_control combines the code in bits 2:0 with the range bit 6 to give fifteen settings from 0 dB to -12 dB.
// - De-emphasis code 0 gives 0 dB whatever the range bit holds; for any other code a range of 1 gives the milder level and 0 the stronger one.
// - There is one shared register set for all channels and one channel register set for each channel.
// - The shared set holds the selection that decides which channel later channel-address accesses reach.
// - Bit 2 of the select register at 0xff sends accesses to the shared set when 0 and to the channel named by bits 1:0 when 1, until it is rewritten.
// - A write to 0xff always lands in the shared select register, whatever the current selection.
// - While bits 3 and 2 of the select register are both 1, each write to an address other than 0xff reaches every channel set at once.
// - Writes to read-only registers are ignored and leave them unchanged.
package rdc_pkg;
  localparam int unsigned rdc_num_chan = 4;
  localparam int unsigned rdc_chan_bits = 2;

  // Register offsets.
  localparam logic [7:0] rdc_addr_deemph = 8'h15;
  localparam logic [7:0] rdc_addr_swing = 8'h2d;
  localparam logic [7:0] rdc_addr_select = 8'hff;
  localparam logic [7:0] rdc_addr_strap = 8'h00;
  localparam logic [7:0] rdc_addr_version = 8'h01;

  // Field positions.
  localparam int unsigned rdc_swing_lsb = 0;
  localparam int unsigned rdc_swing_width = 3;
  localparam int unsigned rdc_dem_code_lsb = 0;
  localparam int unsigned rdc_dem_code_width = 3;
  localparam int unsigned rdc_dem_range_bit = 6;
  localparam int unsigned rdc_sel_chan_lsb = 0;
  localparam int unsigned rdc_sel_chan_bit = 2;
  localparam int unsigned rdc_sel_bcast_bit = 3;
  localparam int unsigned rdc_sel_width = 4;

  // Reset values.
  localparam logic [7:0] rdc_deemph_reset = 8'h00;
  localparam logic [7:0] rdc_swing_reset = 8'h00;
  localparam logic [3:0] rdc_select_reset = 4'h0;
  localparam logic [7:0] rdc_read_zero = 8'h00;

  // Amplitude in 100 mV steps for swing code 0.
  localparam logic [3:0] rdc_vod_base = 4'h6;
  localparam int unsigned rdc_vod_width = 4;
  localparam int unsigned rdc_dem_level_width = 4;
endpackage

// >>> verilog/rdc_chan_regs.sv
module rdc_chan_regs
  import rdc_pkg::*;
(
  // Clock and reset.
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // Write port.
  input wire logic wr_en_i,
  input wire logic [7:0] wr_addr_i,
  input wire logic [7:0] wr_data_i,
  // Stored registers.
  output logic [7:0] deemph_o,
  output logic [7:0] swing_o
);
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      deemph_o <= rdc_deemph_reset;
    end else if (wr_en_i && wr_addr_i == rdc_addr_deemph) begin
      deemph_o <= wr_data_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      swing_o <= rdc_swing_reset;
    end else if (wr_en_i && wr_addr_i == rdc_addr_swing) begin
      swing_o <= wr_data_i;
    end
  end
endmodule

// >>> verilog/rdc_driver_config.sv
module rdc_driver_config
  import rdc_pkg::*;
#(
  parameter int unsigned NUM_CHAN = rdc_pkg::rdc_num_chan,
  // Arbitrary version value, read back from the shared set.
  parameter logic [7:0] VERSION_CODE = 8'h5a
)
(
  // Clock and reset.
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // Register access from the management bus engine.
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_rd_i,
  input wire logic [3:0] strap_addr_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  output logic reg_wack_o,
  // Channel selection state.
  output logic [rdc_pkg::rdc_sel_width-1:0] chan_select_o,
  // Driver settings, one slice per channel.
  output logic [NUM_CHAN*rdc_pkg::rdc_swing_width-1:0] swing_code_o,
  output logic [NUM_CHAN*rdc_pkg::rdc_vod_width-1:0] vod_step_o,
  output logic [NUM_CHAN*rdc_pkg::rdc_dem_code_width-1:0] dem_code_o,
  output logic [NUM_CHAN-1:0] dem_range_o,
  output logic [NUM_CHAN*rdc_pkg::rdc_dem_level_width-1:0] dem_level_o
);
  import rdc_pkg::*;

  logic [7:0] chan_deemph [NUM_CHAN];
  logic [7:0] chan_swing [NUM_CHAN];
  logic [NUM_CHAN-1:0] chan_wr_en;
  logic to_select;
  logic chan_mode;
  logic bcast_mode;
  logic [rdc_chan_bits-1:0] target_chan;
  logic [7:0] next_rdata;
  logic [3:0] strap_q;
  // Level index per channel, worked out from the stored de-emphasis register.
  logic [rdc_dem_level_width-1:0] next_level [NUM_CHAN];

  assign to_select = reg_addr_i == rdc_addr_select;
  assign chan_mode = chan_select_o[rdc_sel_chan_bit];
  assign bcast_mode = chan_mode && chan_select_o[rdc_sel_bcast_bit];
  assign target_chan = chan_select_o[rdc_sel_chan_lsb +: rdc_chan_bits];

  // The select register is shared and always reachable at its own address.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      chan_select_o <= rdc_select_reset;
    end else if (reg_wr_i && to_select) begin
      chan_select_o <= reg_wdata_i[rdc_sel_width-1:0];
    end
  end

  // The strap pins are sampled after reset so the address register reads them.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      strap_q <= 4'h0;
    end else begin
      strap_q <= strap_addr_i;
    end
  end

  // Channel write enables; the shared set holds no writable channel fields.
  always_comb begin
    for (int i = 0; i < NUM_CHAN; i++) begin
      chan_wr_en[i] = 1'b0;
      if (reg_wr_i && !to_select && chan_mode) begin
        if (bcast_mode) begin
          chan_wr_en[i] = 1'b1;
        end else if (target_chan == i[rdc_chan_bits-1:0]) begin
          chan_wr_en[i] = 1'b1;
        end
      end
    end
  end

  // One register set per channel.
  for (genvar g = 0; g < NUM_CHAN; g++) begin : gen_chan
    rdc_chan_regs u_regs (
      .clock_i(clock_i),
      .sys_rst_i(sys_rst_i),
      .wr_en_i(chan_wr_en[g]),
      .wr_addr_i(reg_addr_i),
      .wr_data_i(reg_wdata_i),
      .deemph_o(chan_deemph[g]),
      .swing_o(chan_swing[g])
    );
  end

  // Read mux; shared addresses are read-only apart from the select register.
  always_comb begin
    next_rdata = rdc_read_zero;
    if (to_select) begin
      next_rdata = {{(8 - rdc_sel_width){1'b0}}, chan_select_o};
    end else if (!chan_mode) begin
      case (reg_addr_i)
        rdc_addr_strap: next_rdata = {strap_q, 4'h0};
        rdc_addr_version: next_rdata = VERSION_CODE;
        default: next_rdata = rdc_read_zero;
      endcase
    end else begin
      case (reg_addr_i)
        rdc_addr_deemph: next_rdata = chan_deemph[target_chan];
        rdc_addr_swing: next_rdata = chan_swing[target_chan];
        default: next_rdata = rdc_read_zero;
      endcase
    end
  end

  // Read data is captured only on a read strobe and then holds for the host.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= rdc_read_zero;
    end else if (reg_rd_i) begin
      reg_rdata_o <= next_rdata;
    end
  end

  // One-cycle answer to each read strobe.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
    end
  end

  // One-cycle answer to each write strobe, whether or not the write landed.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      reg_wack_o <= 1'b0;
    end else begin
      reg_wack_o <= reg_wr_i;
    end
  end

  // The driver settings below are registered once more, so every setting
  // follows its register write by two clock cycles.

  // Swing code per channel, taken from the low bits of the stored swing register.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      swing_code_o <= '0;
    end else begin
      for (int i = 0; i < NUM_CHAN; i++) begin
        swing_code_o[i*rdc_swing_width +: rdc_swing_width] <=
          chan_swing[i][rdc_swing_lsb +: rdc_swing_width];
      end
    end
  end

  // Amplitude in 100 mV steps. Code 0 still means the lowest amplitude, so the
  // reset value shows that step rather than zero, which no code can select.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      vod_step_o <= {NUM_CHAN{rdc_vod_base}};
    end else begin
      for (int i = 0; i < NUM_CHAN; i++) begin
        vod_step_o[i*rdc_vod_width +: rdc_vod_width] <=
          rdc_vod_base + {1'b0, chan_swing[i][rdc_swing_lsb +: rdc_swing_width]};
      end
    end
  end

  // De-emphasis code per channel.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      dem_code_o <= '0;
    end else begin
      for (int i = 0; i < NUM_CHAN; i++) begin
        dem_code_o[i*rdc_dem_code_width +: rdc_dem_code_width] <=
          chan_deemph[i][rdc_dem_code_lsb +: rdc_dem_code_width];
      end
    end
  end

  // De-emphasis range bit per channel.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      dem_range_o <= '0;
    end else begin
      for (int i = 0; i < NUM_CHAN; i++) begin
        dem_range_o[i] <= chan_deemph[i][rdc_dem_range_bit];
      end
    end
  end

  // Level 0 is 0 dB whatever the range bit holds. Each nonzero code owns two
  // levels: the odd one is the milder setting, the even one the stronger.
  always_comb begin
    for (int i = 0; i < NUM_CHAN; i++) begin
      next_level[i] = 4'h0;
      if (chan_deemph[i][rdc_dem_code_lsb +: rdc_dem_code_width] != 3'h0) begin
        next_level[i] = {chan_deemph[i][rdc_dem_code_lsb +: rdc_dem_code_width], 1'b0} -
          {3'h0, chan_deemph[i][rdc_dem_range_bit]};
      end
    end
  end

  // Registered level index per channel.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      dem_level_o <= '0;
    end else begin
      for (int i = 0; i < NUM_CHAN; i++) begin
        dem_level_o[i*rdc_dem_level_width +: rdc_dem_level_width] <= next_level[i];
      end
    end
  end
endmodule

// >>> bench/rdc_driver_config_properties.sv
module rdc_driver_config_chk
  import rdc_pkg::*;
#(
  parameter int unsigned NUM_CHAN = 4
)
(
  // Clock and reset.
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // Register access.
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic reg_rvalid_o,
  input wire logic reg_wack_o,
  // Settings.
  input wire logic [rdc_sel_width-1:0] chan_select_o,
  input wire logic [NUM_CHAN*rdc_swing_width-1:0] swing_code_o,
  input wire logic [NUM_CHAN*rdc_vod_width-1:0] vod_step_o,
  input wire logic [NUM_CHAN*rdc_dem_code_width-1:0] dem_code_o,
  input wire logic [NUM_CHAN-1:0] dem_range_o,
  input wire logic [NUM_CHAN*rdc_dem_level_width-1:0] dem_level_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_swing_wr;
    reg_wr_i && reg_addr_i == rdc_addr_swing;
  endsequence
  sequence s_shared_wr;
    reg_wr_i && !chan_select_o[2] && reg_addr_i != rdc_addr_select ##1 !reg_wr_i;
  endsequence
  AST_SEL_WR: assert property (reg_wr_i && reg_addr_i == rdc_addr_select |=>
    chan_select_o == $past(reg_wdata_i[3:0])) else $error("select write lost");
  AST_CH1: assert property (s_swing_wr and chan_select_o[2:0] == 3'h5 |=> ##1
    swing_code_o[5:3] == $past(reg_wdata_i[2:0], 2)) else $error("channel write lost");
  AST_BCAST: assert property (s_swing_wr and chan_select_o[3:2] == 2'b11 |=> ##1
    swing_code_o[2:0] == $past(reg_wdata_i[2:0], 2) &&
    swing_code_o[3*NUM_CHAN-1 -: 3] == swing_code_o[2:0]) else $error("broadcast missed");
  AST_IGN: assert property (s_shared_wr |=> $stable(swing_code_o) && $stable(dem_code_o))
    else $error("channel set changed by shared write");
  AST_RD_SEL: assert property (reg_rd_i && reg_addr_i == rdc_addr_select |=>
    reg_rdata_o == {4'h0, $past(chan_select_o)}) else $error("select readback wrong");
  AST_VOD: assert property (vod_step_o[3:0] == rdc_vod_base + {1'b0, swing_code_o[2:0]})
    else $error("amplitude step wrong");
  AST_DEM0: assert property (dem_code_o[2:0] == 3'h0 |-> dem_level_o[3:0] == 4'h0)
    else $error("zero code not flat");
  AST_DEMN: assert property (dem_code_o[2:0] != 3'h0 |-> dem_level_o[3:0] ==
    {dem_code_o[2:0], 1'b0} - {3'h0, dem_range_o[0]}) else $error("de-emphasis level wrong");
  AST_RVALID: assert property (reg_rvalid_o == $past(reg_rd_i))
    else $error("read answer not one cycle after strobe");
  AST_WACK: assert property (reg_wack_o == $past(reg_wr_i))
    else $error("write answer not one cycle after strobe");
endmodule

bind rdc_driver_config rdc_driver_config_chk #(.NUM_CHAN(NUM_CHAN)) u_rdc_driver_config_chk (
  .clock_i, .sys_rst_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rd_i, .reg_rdata_o,
  .reg_rvalid_o, .reg_wack_o,
  .chan_select_o, .swing_code_o, .vod_step_o, .dem_code_o, .dem_range_o, .dem_level_o);

// >>> bench/rdc_host_model.sv
module rdc_host_model (
  // Clock.
  input wire logic clock_i,
  // Register bus.
  input wire logic [7:0] rdata_i,
  output logic [7:0] addr_o,
  output logic wr_o,
  output logic [7:0] wdata_o,
  output logic rd_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    addr_o = 8'h00;
    wr_o = 1'b0;
    wdata_o = 8'h00;
    rd_o = 1'b0;
  end
  // Released data is inverted so a stale byte can never look valid.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clock_i);
    wr_o <= 1'b0;
    wdata_o <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clock_i);
    rd_o <= 1'b0;
    @(posedge clock_i);
    d = rdata_i;
  endtask
  task automatic rmw(input logic [7:0] a, input logic [7:0] m, input logic [7:0] v);
    logic [7:0] cur;
    rd(a, cur);
    wr(a, (cur & ~m) | (v & m));
  endtask
endmodule

// >>> bench/test_rdc_driver_config.sv
module test_rdc_driver_config;
  timeunit 1ns;
  timeprecision 100ps;
  import rdc_pkg::*;
  logic clock_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [7:0] addr, wdata, rdata, v;
  logic wr, rd;
  logic [3:0] sel;
  logic [11:0] swing;
  logic [15:0] vod, level;
  logic [11:0] code;
  logic [3:0] range;
  int mismatches = 0;
  int checks_done = 0;
  int cycles = 0;
  initial forever #4 clock_i = ~clock_i;
  rdc_host_model u_rdc_host_model (.clock_i(clock_i), .rdata_i(rdata), .addr_o(addr),
    .wr_o(wr), .wdata_o(wdata), .rd_o(rd));
  rdc_driver_config #(.VERSION_CODE(8'ha3)) u_rdc_driver_config (.clock_i(clock_i),
    .sys_rst_i(sys_rst_i), .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wdata),
    .reg_rd_i(rd), .strap_addr_i(4'h9), .reg_rdata_o(rdata), .reg_rvalid_o(), .reg_wack_o(),
    .chan_select_o(sel), .swing_code_o(swing), .vod_step_o(vod), .dem_code_o(code),
    .dem_range_o(range), .dem_level_o(level));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t %h %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    if (mismatches == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic settle;
    repeat (2) @(posedge clock_i);
  endtask
  task automatic t_swing;
    for (int c = 0; c < 8; c++) begin
      u_rdc_host_model.wr(8'hff, 8'h04 | (c % 4));
      u_rdc_host_model.wr(8'h2d, c);
      settle();
      chk(vod[4*(c%4) +: 4], 6 + c);
    end
  endtask
  task automatic t_dem;
    u_rdc_host_model.wr(8'hff, 8'h04);
    for (int i = 0; i < 16; i++) begin
      u_rdc_host_model.wr(8'h15, {1'b0, i[3], 3'h0, i[2:0]});
      settle();
      chk(level[3:0], (i[2:0] == 0) ? 0 : 2 * i[2:0] - i[3]);
      chk(code[2:0], i[2:0]);
      chk(range[0], i[3]);
    end
  endtask
  task automatic t_shared;
    u_rdc_host_model.wr(8'hff, 8'h00);
    u_rdc_host_model.wr(8'h2d, 8'h01);
    u_rdc_host_model.wr(8'h01, 8'h00);
    u_rdc_host_model.rd(8'h01, v);
    chk(v, 8'ha3);
    u_rdc_host_model.rd(8'h00, v);
    chk(v, 8'h90);
    chk(swing, 12'hfac);
    u_rdc_host_model.rd(8'hff, v);
    chk(v, 8'h00);
  endtask
  task automatic t_bcast;
    u_rdc_host_model.wr(8'hff, 8'h0c);
    u_rdc_host_model.wr(8'h2d, 8'h03);
    settle();
    chk(swing, 12'h6db);
    u_rdc_host_model.wr(8'hff, 8'h06);
    u_rdc_host_model.rd(8'hff, v);
    chk(v, 8'h06);
    u_rdc_host_model.wr(8'h2d, 8'h01);
    u_rdc_host_model.wr(8'h15, 8'h05);
    u_rdc_host_model.rmw(8'h15, 8'h40, 8'h40);
    settle();
    chk(swing, 12'h65b);
    chk(range, 4'h5);
    chk(code[8:6], 3'h5);
    chk(level[11:8], 4'h9);
  endtask
  task automatic t_reset;
    @(posedge clock_i);
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    @(posedge clock_i);
    chk(sel, 4'h0);
    chk(swing, 12'h000);
    chk(vod, 16'h6666);
    chk(level, 16'h0000);
    chk(range, 4'h0);
    u_rdc_host_model.wr(8'hff, 8'h04);
    u_rdc_host_model.wr(8'h2d, 8'h02);
    settle();
    chk(vod, 16'h6668);
  endtask
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      mismatches++;
      test_done();
    end
  end
  initial begin
    repeat (16) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    @(posedge clock_i);
    chk(sel, 4'h0);
    chk(vod, 16'h6666);
    t_swing();
    t_shared();
    t_dem();
    t_bcast();
    t_reset();
    test_done();
  end
endmodule
